// ---- rmcs_mon.sv ----
// Constants package and the per-input activity monitor.
// Assumes mon_tick is a one-cycle enable on ref_clk; pins are asynchronous.
package rmcs_pkg;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_DIV0 = 8'h04;
    localparam logic [7:0] A_DIV1 = 8'h08;
    localparam logic [7:0] A_CHD0 = 8'h0c;
    localparam logic [7:0] A_CHD1 = 8'h10;
    localparam logic [7:0] A_HOLD = 8'h14;
    localparam logic [7:0] A_PRESC = 8'h18;
    localparam logic [7:0] A_STAT = 8'h1c;
    localparam logic [7:0] A_LOSS = 8'h20;
    localparam int CT_BYP = 0;
    localparam int CT_FBR = 1;
    localparam int CT_DBL = 2;
    localparam int CT_SRC = 3;
    localparam int CT_REV = 4;
    localparam int CT_BLK = 5;
    localparam int CT_MPD = 6;
    localparam int CT_MODE = 8;
    localparam int CT_MSEL = 10;
    localparam int CT_CP = 16;
    localparam int DV_HI = 16;
    localparam int DV_MF = 23;
    localparam int HD_REVAL = 8;
    localparam int HD_PRIO = 16;
    localparam int ST_SEL = 4;
    localparam int ST_HOLD = 6;
    localparam int ST_REF = 7;
    localparam int LOSS_REF = 4;
    localparam logic [11:0] RST_PV = 12'h001;
    localparam logic [8:0] RST_MV1 = 9'h00f;
    localparam logic [5:0] RST_PF = 6'h01;
    localparam logic [8:0] RST_MF = 9'h00f;
    localparam logic [7:0] RST_CHD = 8'h01;
    localparam logic [7:0] RST_REVAL = 8'h04;
    localparam logic [23:0] RST_PRESC = 24'h020000;
    localparam logic [1:0] MISS_LIMIT = 2'h3;
    localparam logic [7:0] CH_DIV_MAX = 8'hc8;
    typedef enum logic [1:0] {
        MODE_MANUAL,
        MODE_AUTO,
        MODE_HOLD,
        MODE_AUTO_HOLD
    } rmcs_mode_e;
endpackage

`timescale 1ns/1ps
`default_nettype none
module rmcs_mon (
    input wire logic ref_clk, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic clk_pin, // Raw reference input
    input wire logic diff_zero, // Raw zero-differential detect
    input wire logic mon_tick, // Monitor reference period tick
    input wire logic [7:0] reval_count, // Periods needed to revalidate
    output logic valid, // Input currently valid
    output logic los_event // Pulse when the input is declared lost
);
    import rmcs_pkg::*;

    typedef struct packed {
        logic [1:0] ck_s;
        logic [1:0] dz_s;
        logic ck_l;
        logic seen;
        logic [1:0] miss;
        logic [7:0] good;
        logic valid;
        logic ev;
    } rmcs_mon_s;

    rmcs_mon_s s_q, s_d;
    logic edge_now;
    logic [7:0] need;

    assign edge_now = s_q.ck_s[1] & ~s_q.ck_l;
    assign need = (reval_count == 8'h00) ? 8'h01 : reval_count;

    always_comb begin
        s_d = s_q;
        s_d.ck_s = {s_q.ck_s[0], clk_pin};
        s_d.dz_s = {s_q.dz_s[0], diff_zero};
        s_d.ck_l = s_q.ck_s[1];
        s_d.ev = 1'b0;
        if (edge_now) begin
            s_d.seen = 1'b1;
        end
        // A mismatched monitor rate either delays or falsely raises loss
        if (mon_tick) begin
            s_d.seen = 1'b0;
            if (edge_now || s_q.seen) begin
                s_d.miss = 2'h0;
                if (!s_q.valid) begin
                    if ({1'b0, s_q.good} + 9'h001 >= {1'b0, need}) begin
                        s_d.valid = 1'b1;
                        s_d.good = 8'h00;
                    end else begin
                        s_d.good = s_q.good + 8'h01;
                    end
                end
            end else begin
                s_d.good = 8'h00;
                if (s_q.miss == MISS_LIMIT - 2'h1) begin
                    s_d.valid = 1'b0;
                    s_d.ev = s_q.valid;
                end else begin
                    s_d.miss = s_q.miss + 2'h1;
                end
            end
        end
        if (s_q.dz_s[1]) begin
            s_d.valid = 1'b0;
            s_d.good = 8'h00;
            s_d.ev = s_q.valid;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign valid = s_q.valid;
    assign los_event = s_q.ev;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_third_miss;
        mon_tick && !edge_now && !s_q.seen && s_q.valid && s_q.miss == 2'h2;
    endsequence

    a_third_miss: assert property (s_third_miss |=> !valid && los_event)
        else $error("third missing edge did not drop valid");
    a_edge_clears: assert property (mon_tick && edge_now |=> s_q.miss == 2'h0)
        else $error("edge did not clear miss count");
    a_zero_diff: assert property (s_q.dz_s[1] |=> !valid)
        else $error("zero differential did not drop valid");
endmodule
`default_nettype wire

// ---- rmcs_src_model.sv ----
// Behavioural model of the four reference clock sources.
// Assumes ref_clk is the bench clock; run gates each source separately.
`timescale 1ns/1ps
`default_nettype none
module rmcs_src_model #(
    parameter int HALF = 3 // Half period in ref_clk cycles
) (
    input wire logic ref_clk, // Bench clock
    input wire logic [3:0] run, // Source running
    output logic [3:0] clk_in // Reference clocks
);
    int cnt = 0;
    initial clk_in = '0;
    // A stopped source stays static, which the monitors must treat as lost.
    // Sources run faster than the monitor reference: detection only slows down.
    always @(posedge ref_clk) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == 0) begin
            clk_in <= clk_in ^ run;
        end
    end
endmodule
`default_nettype wire

// ---- rmcs_top.sv ----
// Reference monitor, input selection and PLL routing settings, APB slave.
// Assumes vco_tick and vcxo_tick are one-cycle enables on ref_clk that stand
// for VCO and first-loop output edges; clk_in and diff_zero are async pins.
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rmcs_top (
    input wire logic ref_clk, // 200 MHz clock
    input wire logic rst, // Async reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic [3:0] clk_in, // Reference inputs
    input wire logic [3:0] diff_zero, // Zero differential detect per input
    input wire logic vco_tick, // VCO edge enable
    input wire logic vcxo_tick, // First loop output edge enable
    output logic [3:0] input_valid, // Per-input validity
    output logic [1:0] active_sel, // Selected reference
    output logic holdover, // Holdover active
    output logic ref_valid, // Selected reference good
    output logic first_loop_bypass, // First loop disabled
    output logic pll2_ref_from_input, // Second loop fed by pre-divided input
    output logic feedback_route_select, // Feedback through monitor divider too
    output logic doubler_enable, // Second loop input doubled
    output logic second_prediv_used, // Second pre-divider in path
    output logic divider_source_select, // Output dividers from first loop
    output logic [11:0] input_prediv, // Input pre-divider value
    output logic [11:0] first_feedback_div, // First feedback divider value
    output logic [8:0] monitor_divider, // Monitor divider value
    output logic [5:0] second_prediv, // Second pre-divider value
    output logic [8:0] second_feedback_div, // Second feedback divider value
    output logic [4:0] cp_code, // Charge pump code, 50 uA per step above 50 uA
    output logic [4:0] ch_tick // Channel divider output pulses
);
    import rmcs_pkg::*;

    typedef struct packed {
        logic byp, fbr, dbl, src, rev, blk, mpd;
        rmcs_mode_e mode;
        logic [1:0] msel;
        logic [4:0] cp;
        logic [11:0] pv, mv0;
        logic [8:0] mv1, mf;
        logic [5:0] pf;
        logic [4:0][7:0] chd;
        logic [4:0][7:0] ccnt;
        logic [4:0] ctick;
        logic [7:0] hstart, reval, prio;
        logic [23:0] presc, pcnt;
        logic [7:0] hcnt;
        logic [8:0] mcnt;
        logic mtick;
        logic [1:0] sel;
        logic hold, expired, ref_ok, rloss;
        logic [3:0] iloss;
        logic [31:0] rdata;
    } rmcs_top_s;

    rmcs_top_s s_q, s_d;
    logic [3:0] valid, los_ev;
    logic [2:0] pick;
    logic [7:0] hit;
    logic wr, setup, htick, higher;

    function automatic logic [2:0] best_pick(input logic [3:0] v, input logic [7:0] pr);
        logic [2:0] r;
        logic [1:0] bp;
        r = 3'h0;
        bp = 2'h0;
        for (int i = 0; i < 4; i++) begin
            if (v[i] && (!r[2] || pr[2*i+:2] > bp)) begin
                r = {1'b1, 2'(i)};
                bp = pr[2*i+:2];
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] ch_lim(input logic [7:0] v);
        if (v == 8'h00) begin
            return 8'h01;
        end
        return (v > CH_DIV_MAX) ? CH_DIV_MAX : v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // One monitor per input, all sharing the monitor reference tick

    for (genvar g = 0; g < 4; g++) begin : g_mon
        rmcs_mon u_mon (
            .ref_clk(ref_clk),
            .rst(rst),
            .clk_pin(clk_in[g]),
            .diff_zero(diff_zero[g]),
            .mon_tick(s_q.mtick),
            .reval_count(s_q.reval),
            .valid(valid[g]),
            .los_event(los_ev[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Decode

    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite;
    assign pick = best_pick(valid, s_q.prio);
    assign higher = pick[2] && (s_q.prio[2*pick[1:0]+:2] > s_q.prio[2*s_q.sel+:2]);
    always_comb begin
        hit = 8'h00;
        unique case (paddr)
            A_CTRL: hit = 8'h01;
            A_DIV0: hit = 8'h02;
            A_DIV1: hit = 8'h04;
            A_CHD0: hit = 8'h08;
            A_CHD1: hit = 8'h10;
            A_HOLD: hit = 8'h20;
            A_PRESC: hit = 8'h40;
            A_STAT: hit = 8'h80;
            A_LOSS: hit = 8'h80;
            default: hit = 8'h00;
        endcase
    end
    // Hold-off prescaler wraps only while waiting out a loss in mode 11
    assign htick = vcxo_tick && (s_q.pcnt + 24'h000001 >= s_q.presc);

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_d = s_q;
        s_d.mtick = 1'b0;
        // Monitor divider stops when powered down, so only zero differential can flag a loss
        if (vco_tick && !s_q.mpd) begin
            if (s_q.mcnt + 9'h001 >= s_q.mv1) begin
                s_d.mcnt = 9'h000;
                s_d.mtick = 1'b1;
            end else begin
                s_d.mcnt = s_q.mcnt + 9'h001;
            end
        end
        // Channel dividers run from the chosen source clock
        for (int i = 0; i < 5; i++) begin
            s_d.ctick[i] = 1'b0;
            if (s_q.src ? vcxo_tick : vco_tick) begin
                if (s_q.ccnt[i] + 8'h01 >= ch_lim(s_q.chd[i])) begin
                    s_d.ccnt[i] = 8'h00;
                    s_d.ctick[i] = 1'b1;
                end else begin
                    s_d.ccnt[i] = s_q.ccnt[i] + 8'h01;
                end
            end
        end

        // Input selection
        unique case (s_q.mode)
            MODE_MANUAL: begin
                s_d.sel = s_q.msel;
                s_d.hold = 1'b0;
            end
            MODE_AUTO: begin
                s_d.hold = 1'b0;
                if (!valid[s_q.sel]) begin
                    if (pick[2]) begin
                        s_d.sel = pick[1:0];
                    end
                end else if (s_q.rev && higher) begin
                    s_d.sel = pick[1:0];
                end
            end
            MODE_HOLD: begin
                s_d.sel = s_q.msel;
                s_d.hold = !valid[s_q.msel];
            end
            MODE_AUTO_HOLD: begin
                if (!s_q.hold) begin
                    if (!valid[s_q.sel]) begin
                        s_d.hold = 1'b1;
                        s_d.hcnt = s_q.hstart;
                        s_d.expired = 1'b0;
                    end else if (s_q.rev && higher) begin
                        s_d.sel = pick[1:0];
                    end
                end else if (s_q.expired) begin
                    if (pick[2]) begin
                        s_d.sel = pick[1:0];
                        s_d.hold = 1'b0;
                    end
                end else if (htick) begin
                    if (s_q.hcnt == 8'h00) begin
                        s_d.hcnt = s_q.hstart;
                        if (valid[s_q.sel]) begin
                            s_d.hold = 1'b0;
                        end else if (pick[2]) begin
                            s_d.sel = pick[1:0];
                            s_d.hold = 1'b0;
                        end else begin
                            s_d.expired = 1'b1;
                        end
                    end else begin
                        s_d.hcnt = s_q.hcnt - 8'h01;
                    end
                end
            end
        endcase
        if (s_q.mode == MODE_AUTO_HOLD && s_q.hold && !s_q.expired) begin
            if (vcxo_tick) begin
                s_d.pcnt = htick ? 24'h000000 : s_q.pcnt + 24'h000001;
            end
        end else begin
            s_d.pcnt = 24'h000000;
        end
        s_d.ref_ok = valid[s_d.sel] && !s_d.hold;

        // Register writes; clears come first so a same-cycle set wins
        if (wr && hit[0]) begin
            s_d.byp = pwdata[CT_BYP];
            s_d.fbr = pwdata[CT_FBR];
            s_d.dbl = pwdata[CT_DBL];
            s_d.src = pwdata[CT_SRC];
            s_d.rev = pwdata[CT_REV];
            s_d.blk = pwdata[CT_BLK];
            s_d.mpd = pwdata[CT_MPD];
            s_d.mode = rmcs_mode_e'(pwdata[CT_MODE+:2]);
            s_d.msel = pwdata[CT_MSEL+:2];
            s_d.cp = pwdata[CT_CP+:5];
        end
        if (wr && hit[1]) begin
            s_d.pv = pwdata[11:0];
            s_d.mv0 = pwdata[DV_HI+:12];
        end
        if (wr && hit[2]) begin
            s_d.mv1 = pwdata[8:0];
            s_d.pf = pwdata[DV_HI+:6];
            s_d.mf = pwdata[DV_MF+:9];
        end
        if (wr && hit[3]) begin
            s_d.chd[3:0] = pwdata;
        end
        if (wr && hit[4]) begin
            s_d.chd[4] = pwdata[7:0];
        end
        if (wr && hit[5]) begin
            s_d.hstart = pwdata[7:0];
            s_d.reval = pwdata[HD_REVAL+:8];
            s_d.prio = pwdata[HD_PRIO+:8];
        end
        if (wr && hit[6]) begin
            s_d.presc = pwdata[23:0];
        end
        if (wr && paddr == A_LOSS) begin
            s_d.iloss = s_q.iloss & ~(pwdata[3:0] & valid);
            if (pwdata[LOSS_REF] && s_q.ref_ok) begin
                s_d.rloss = 1'b0;
            end
        end
        s_d.iloss = s_d.iloss | (los_ev & {4{!s_q.blk}});
        if (s_q.ref_ok && !s_d.ref_ok) begin
            s_d.rloss = 1'b1;
        end

        // Read data is captured in the setup phase
        if (setup) begin
            unique case (paddr)
                A_CTRL: s_d.rdata = {11'h000, s_q.cp, 4'h0, s_q.msel, s_q.mode, 1'b0,
                                     s_q.mpd, s_q.blk, s_q.rev, s_q.src, s_q.dbl,
                                     s_q.fbr, s_q.byp};
                A_DIV0: s_d.rdata = {4'h0, s_q.mv0, 4'h0, s_q.pv};
                A_DIV1: s_d.rdata = {s_q.mf, 1'b0, s_q.pf, 7'h00, s_q.mv1};
                A_CHD0: s_d.rdata = s_q.chd[3:0];
                A_CHD1: s_d.rdata = {24'h000000, s_q.chd[4]};
                A_HOLD: s_d.rdata = {8'h00, s_q.prio, s_q.reval, s_q.hstart};
                A_PRESC: s_d.rdata = {8'h00, s_q.presc};
                A_STAT: s_d.rdata = {24'h000000, s_q.ref_ok, s_q.hold, s_q.sel, valid};
                A_LOSS: s_d.rdata = {27'h0000000, s_q.rloss, s_q.iloss};
                default: s_d.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.pv <= RST_PV;
            s_q.mv0 <= RST_PV;
            s_q.mv1 <= RST_MV1;
            s_q.pf <= RST_PF;
            s_q.mf <= RST_MF;
            s_q.chd <= {5{RST_CHD}};
            s_q.reval <= RST_REVAL;
            s_q.presc <= RST_PRESC;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata = s_q.rdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & (hit == 8'h00);
    assign input_valid = valid;
    assign active_sel = s_q.sel;
    assign holdover = s_q.hold;
    assign ref_valid = s_q.ref_ok;
    assign first_loop_bypass = s_q.byp;
    assign pll2_ref_from_input = s_q.byp;
    assign feedback_route_select = s_q.fbr;
    assign doubler_enable = s_q.dbl;
    assign second_prediv_used = !s_q.dbl;
    assign divider_source_select = s_q.src;
    assign input_prediv = s_q.pv;
    assign first_feedback_div = s_q.mv0;
    assign monitor_divider = s_q.mv1;
    assign second_prediv = s_q.pf;
    assign second_feedback_div = s_q.mf;
    assign cp_code = s_q.cp;
    assign ch_tick = s_q.ctick;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_ref_drop;
        s_q.ref_ok ##1 !s_q.ref_ok;
    endsequence

    a_manual_fixed: assert property (s_q.mode == MODE_MANUAL |=> s_q.sel == $past(s_q.msel))
        else $error("manual mode did not follow selection");
    a_auto_switch: assert property (s_q.mode == MODE_AUTO && !valid[s_q.sel] && pick[2]
                                    |=> s_q.sel == $past(pick[1:0]))
        else $error("automatic mode did not switch");
    a_auto_nohold: assert property (s_q.mode == MODE_AUTO |=> !s_q.hold)
        else $error("automatic mode entered holdover");
    a_hold_entry: assert property (s_q.mode == MODE_AUTO_HOLD && !s_q.hold && !valid[s_q.sel]
                                   |=> s_q.hold && s_q.hcnt == $past(s_q.hstart))
        else $error("holdover not entered with start value");
    a_revert_higher: assert property (s_q.mode == MODE_AUTO && valid[s_q.sel] && !s_q.rev
                                      |=> $stable(s_q.sel))
        else $error("switch without revertive enable");
    a_ref_loss: assert property (s_ref_drop |-> s_q.rloss)
        else $error("reference loss not latched");
    a_presc_idle: assert property (s_q.mode != MODE_AUTO_HOLD |=> s_q.pcnt == 24'h000000)
        else $error("hold-off prescaler ran outside mode 11");
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the reference monitor and clock select block.
// Assumes the design files and the source model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rmcs_pkg::*;
    logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, er;
    logic vco_tick = 0, vcxo_tick = 0, pready, pslverr, holdover, ref_valid;
    logic byp, p2in, fbr, dbl, pfu, src;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, r;
    logic [3:0] clk_in, run = '0, diff_zero = '0, input_valid;
    logic [1:0] active_sel;
    logic [4:0] cp_code, ch_tick;
    logic [7:0] dv[6];
    logic [11:0] ipv, ffd;
    logic [8:0] mdv, sfd;
    logic [5:0] spv;
    int n_errors = 0, n_checks = 0, n, g;
    rmcs_src_model u_rmcs_src_model (.ref_clk(ref_clk), .run(run), .clk_in(clk_in));
    rmcs_top u_rmcs_top (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clk_in(clk_in), .diff_zero(diff_zero), .vco_tick(vco_tick),
        .vcxo_tick(vcxo_tick), .input_valid(input_valid), .active_sel(active_sel),
        .holdover(holdover), .ref_valid(ref_valid), .first_loop_bypass(byp),
        .pll2_ref_from_input(p2in), .feedback_route_select(fbr), .doubler_enable(dbl),
        .second_prediv_used(pfu), .divider_source_select(src), .input_prediv(ipv),
        .first_feedback_div(ffd), .monitor_divider(mdv), .second_prediv(spv),
        .second_feedback_div(sfd), .cp_code(cp_code), .ch_tick(ch_tick));
    initial forever #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) vcxo_tick <= 1'($urandom_range(1));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            n_errors++;
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Returns the cycle count to reach e, then lets the selection settle
    task automatic wv(input logic [3:0] e);
        n = 0;
        while (input_valid !== e && n < 3000) begin
            @(posedge ref_clk);
            n++;
        end
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic gap();
        g = 0;
        do begin
            @(posedge ref_clk);
            g++;
        end while (ch_tick[4] !== 1'b1 && g < 500);
    endtask
    function automatic logic [1:0] best(input logic [7:0] pr, input logic [3:0] v);
        int b;
        b = -1;
        for (int i = 3; i >= 0; i--) begin
            if (v[i] && (b < 0 || pr[2*i+:2] >= pr[2*b+:2])) b = i;
        end
        return 2'(b);
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // The whole sequence needs about 2k cycles; this margin is generous
    initial begin
        #200000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'ha9bb));
        dv = '{8'h00, 8'h01, 8'h07, CH_DIV_MAX, 8'hc9, 8'h00};
        dv[5] = 8'(2 + $urandom_range(197));
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        vco_tick <= 1'b1;
        apb(0, A_DIV1, 0);
        chk(rd, {RST_MF, 1'b0, RST_PF, 7'h0, RST_MV1});
        chk({sfd, spv, mdv}, {RST_MF, RST_PF, RST_MV1});
        apb(0, 8'h24, 0);
        chk(rd, 0);
        chk(er, 1);
        repeat (8) begin
            r = $urandom;
            apb(1, A_CTRL, {11'h0, r[8:4], 12'h0, r[3:0]});
            repeat (2) @(posedge ref_clk);
            chk({byp, p2in, fbr, dbl, pfu, src, cp_code},
                {r[0], r[0], r[1], r[2], ~r[2], r[3], r[8:4]});
        end
        apb(1, A_PRESC, 32'h2);
        // Equal pre-divider and feedback divider keep the phase detector legal
        apb(1, A_DIV0, 32'h00100010);
        repeat (2) @(posedge ref_clk);
        chk({ffd, ipv}, 24'h010010);
        apb(1, A_HOLD, 32'h008d0410);
        apb(1, A_CTRL, 32'h0800);
        run <= 4'hf;
        wv(4'hf);
        chk(input_valid, 4'hf);
        chk(active_sel, 2);
        foreach (dv[k]) begin
            apb(1, A_CHD1, {24'h0, dv[k]});
            gap();
            gap();
            chk(g, (dv[k] == 0) ? 1 : (dv[k] > CH_DIV_MAX) ? CH_DIV_MAX : dv[k]);
        end
        run <= 4'hb;
        wv(4'hb);
        chk(n >= 28 && n <= 70, 1);
        chk({active_sel, holdover, ref_valid}, 4'h8);
        apb(1, A_LOSS, 32'h1f);
        apb(0, A_LOSS, 0);
        chk(rd, 32'h14);
        run <= 4'hf;
        wv(4'hf);
        chk(n >= 40 && n <= 90, 1);
        apb(1, A_LOSS, 32'h1f);
        apb(0, A_LOSS, 0);
        chk(rd, 0);
        apb(1, A_CTRL, 32'h0a00);
        run <= 4'hb;
        wv(4'hb);
        chk({active_sel, holdover, ref_valid}, 4'ha);
        run <= 4'hf;
        wv(4'hf);
        chk({active_sel, holdover, ref_valid}, 4'h9);
        apb(1, A_CTRL, 32'h0400);
        apb(1, A_CTRL, 32'h0500);
        run <= 4'hd;
        wv(4'hd);
        chk(active_sel, best(8'h8d, 4'hd));
        run <= 4'h0;
        wv(4'h0);
        chk({active_sel, holdover}, {best(8'h8d, 4'hd), 1'b0});
        run <= 4'h1;
        wv(4'h1);
        chk(active_sel, 0);
        apb(1, A_CTRL, 32'h0110);
        run <= 4'hf;
        wv(4'hf);
        chk(active_sel, best(8'h8d, 4'hf));
        apb(1, A_CTRL, 32'h0700);
        run <= 4'hd;
        wv(4'hd);
        chk({active_sel, holdover}, 3'b011);
        g = 0;
        while (holdover !== 1'b0 && g < 500) begin
            @(posedge ref_clk);
            g++;
        end
        chk(g >= 24 && g < 500, 1);
        chk(active_sel, best(8'h8d, 4'hd));
        run <= 4'hf;
        wv(4'hf);
        diff_zero <= 4'h1;
        wv(4'he);
        chk(n <= 6, 1);
        diff_zero <= 4'h0;
        tally_and_finish();
    end
endmodule
`default_nettype wire
